/* File: dv/afifo_strobe_model.sv */
// producer and consumer logic that drives the strobes and the data word
`timescale 1ns/1ns
module afifo_strobe_model (
  clk,
  load_strobe,
  unload_strobe,
  data_in
);
  input  wire logic                      clk;
  output afifo_pkg::afifo_word_type      data_in;
  output logic                           load_strobe;
  output logic                           unload_strobe;

  initial begin
    load_strobe   = 1'b0;
    unload_strobe = 1'b0;
    data_in       = 5'h00;
  end

  // one strobe period of 120 ns, 60 ns high and 60 ns low; data held throughout, then inverted
  task automatic pulse(input logic ld, input logic ul, input afifo_pkg::afifo_word_type d);
    @(posedge clk);
    data_in       <= d;
    load_strobe   <= ld;
    unload_strobe <= ul;
    repeat (6) @(posedge clk);
    load_strobe   <= 1'b0;
    unload_strobe <= 1'b0;
    repeat (6) @(posedge clk);
    data_in       <= ~d;
  endtask
endmodule // afifo_strobe_model

/* File: dv/tb.sv */
// self-checking bench of the 16x5 strobed fifo against a queue model
`timescale 1ns/1ns
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin mismatches++; $display("FAIL %0t %s", $time, m); end end
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reset_n = 1'b1;
  logic drive_en = 1'b1;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rd;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [4:0] q_out, q_oe;
  wire  [4:0] q_pin;
  wire  load_strobe, unload_strobe;
  afifo_pkg::afifo_word_type data_in;
  afifo_pkg::afifo_flags_type flags_out;
  int mismatches = 0, checks_done = 0, cyc = 0;
  integer seed = 32'h4f52;
  logic [31:0] scratch;
  logic [4:0] model_q[$];

  always #5 clk = ~clk;

  for (genvar g = 0; g < 5; g++) begin : g_pin
    assign q_pin[g] = q_oe[g] ? q_out[g] : 1'bz;
  end

  afifo_strobe_model link_u (.clk(clk), .load_strobe(load_strobe),
    .unload_strobe(unload_strobe), .data_in(data_in));

  afifo_top dut_u (.clk(clk), .rst(rst), .load_strobe(load_strobe),
    .unload_strobe(unload_strobe), .reset_n(reset_n), .drive_en(drive_en), .data_in(data_in),
    .q_out(q_out), .q_oe(q_oe), .flags_out(flags_out), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rd), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  function automatic logic [3:0] exp_flags(int n);
    return {n != 16, n != 15, n != 0, n != 1};
  endfunction

  task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rd;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // both events are judged against the occupancy before them
  task automatic op(input logic ld, input logic ul);
    logic [4:0] d;
    int         n;
    d = 5'($random(seed));
    n = model_q.size();
    link_u.pulse(ld, ul, d);
    if (ul && n > 0) void'(model_q.pop_front());
    if (ld && n < 16) model_q.push_back(d);
    `CHK(flags_out, exp_flags(model_q.size()), "status flags")
    if (model_q.size() > 0) `CHK(q_pin, model_q[0], "head word")
  endtask

  task automatic check_status();
    logic [31:0] s;
    axi_read(32'h0000_0004, s);
    `CHK(s, {19'h0, drive_en, exp_flags(model_q.size()), 3'h0, 5'(model_q.size())},
         "status register")
    if (model_q.size() > 0) begin
      axi_read(32'h0000_0008, s);
      `CHK(s, {27'h0, model_q[0]}, "data register")
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      $display("FAIL %0t timeout", $time);
      end_of_test();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(flags_out, 4'hd, "flags after reset")
    // fill past full: the seventeenth load is ignored
    for (int i = 0; i < 17; i++) begin
      op(1'b1, 1'b0);
      `CHK(flags_out.no_room_n, model_q.size() != 16, "no room flag")
      `CHK(flags_out.one_slot_n, model_q.size() != 15, "one slot flag")
    end
    check_status();
    $display("test fill done");
    // float the outputs, flags stay driven
    drive_en <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK(q_pin, 5'bzzzzz, "outputs floated")
    `CHK(flags_out, 4'h7, "flags while floated")
    check_status();
    drive_en <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK(q_pin, model_q[0], "outputs driven again")
    $display("test float done");
    // load and unload together while full: only the unload applies
    op(1'b1, 1'b1);
    // drain past empty: order kept, last unloads ignored
    for (int i = 0; i < 17; i++) begin
      op(1'b0, 1'b1);
      `CHK(flags_out.one_word_n, model_q.size() != 1, "one word flag")
    end
    $display("test drain done");
    // first load into empty shows the word at once, then overlapped events
    op(1'b1, 1'b0);
    `CHK(q_pin, model_q[0], "first word shown")
    op(1'b1, 1'b0);
    for (int i = 0; i < 4; i++) op(1'b1, 1'b1);
    check_status();
    $display("test overlap done");
    // reset pin clears the pointers
    reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    model_q.delete();
    `CHK(flags_out, 4'hd, "flags after reset pin")
    op(1'b1, 1'b0);
    op(1'b1, 1'b0);
    $display("test reset pin done");
    // control write without the clear bit and a write to the data word change nothing
    axi_write(32'h0000_0000, 32'h0000_0002);
    `CHK(resp, 2'h0, "control write answer")
    axi_write(32'h0000_0008, 32'h0000_0001);
    `CHK(resp, 2'h0, "data write answer")
    axi_read(32'h0000_0000, scratch);
    `CHK(scratch, 32'h0000_0000, "control reads zero")
    check_status();
    // soft clear through the control register, then unmapped accesses
    axi_write(32'h0000_0000, 32'h0000_0001);
    `CHK(resp, 2'h0, "clear write answer")
    repeat (3) @(posedge clk);
    model_q.delete();
    check_status();
    op(1'b1, 1'b0);
    axi_read(32'h0000_0040, scratch);
    `CHK(resp, 2'h3, "unmapped read answer")
    `CHK(scratch, 32'h0000_0000, "unmapped read data")
    axi_write(32'h0000_0044, 32'h0000_0001);
    `CHK(resp, 2'h3, "unmapped write answer")
    check_status();
    $display("test registers done");
    end_of_test();
  end
endmodule // tb

/* File: logic/afifo_pkg.sv */
// types shared by the 16x5 strobed fifo
package afifo_pkg;

  typedef logic [4:0] afifo_word_type;
  typedef logic [4:0] afifo_ptr_type;

  typedef struct packed {
    logic no_room_n;
    logic one_slot_n;
    logic no_words_n;
    logic one_word_n;
  } afifo_flags_type;

  typedef struct packed {
    logic load;
    logic unload;
    logic reset_n;
    logic drive_en;
  } afifo_pins_type;

endpackage

/* File: logic/afifo_regs.svh */
// constants of the 16x5 strobed fifo: geometry, register map, reset values, timing
`ifndef AFIFO_REGS_SVH
`define AFIFO_REGS_SVH

//------------------------------------------------------------
// geometry
//------------------------------------------------------------
`define AFIFO_DEPTH           5'h10
`define AFIFO_DEPTH_M1        5'h0f
`define AFIFO_ONE             5'h01
`define AFIFO_ZERO            5'h00

//------------------------------------------------------------
// register byte offsets
//------------------------------------------------------------
`define AFIFO_CTRL_OFF        32'h0000_0000
`define AFIFO_STATUS_OFF      32'h0000_0004
`define AFIFO_DATA_OFF        32'h0000_0008

//------------------------------------------------------------
// field positions
//------------------------------------------------------------
`define AFIFO_CTRL_CLR_BIT    0
`define AFIFO_STAT_CNT_LSB    0
`define AFIFO_STAT_FLAG_LSB   8
`define AFIFO_STAT_OE_BIT     12

//------------------------------------------------------------
// reset values and bus answers
//------------------------------------------------------------
`define AFIFO_FLAGS_RST       4'hd
`define AFIFO_PINS_RST        4'h2
`define AFIFO_RESP_OKAY       2'h0
`define AFIFO_RESP_DECERR     2'h3

//------------------------------------------------------------
// timing
//------------------------------------------------------------
`define AFIFO_CLK_PERIOD_NS   10
`define AFIFO_STROBE_MAX_MHZ  40
`define AFIFO_STROBE_MIN_NS   (1000 / `AFIFO_STROBE_MAX_MHZ)
`define AFIFO_STROBE_MIN_CYC  ((`AFIFO_STROBE_MIN_NS + `AFIFO_CLK_PERIOD_NS - 1) / `AFIFO_CLK_PERIOD_NS)

`endif

/* File: logic/afifo_top.sv */
// 16x5 fifo with strobed load and unload pins, status flags and an axi4-lite slave
`timescale 1ns/1ns
`include "afifo_regs.svh"

// Function
// - sixteen five-bit words, delivered in order
// - strobes independent, standstill up to 40 MHz
// - load rising edge stores input word
// - unload rising edge drops oldest, shows next
// - full when loads exceed unloads by sixteen
// - loads ignored entirely while full
// - unloads ignored entirely while empty
// - no-room flag low at sixteen words
// - one-slot flag low at fifteen words
// - no-words flag low at zero words
// - one-word flag low at one word
// - reset low clears pointers, sets flags
// - reset leaves data outputs undefined
// - first load shows word, raises no-words
// - shown word stays until unloaded
// - outputs equal inputs, not inverted
// - drive enable low floats data outputs
// - drive enable never touches status flags
module afifo_top (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      load_strobe,
  input  wire logic                      unload_strobe,
  input  wire logic                      reset_n,
  input  wire logic                      drive_en,
  input  wire afifo_pkg::afifo_word_type data_in,
  output logic      [4:0]                q_out,
  output logic      [4:0]                q_oe,
  output afifo_pkg::afifo_flags_type     flags_out,
  input  wire logic [31:0]               s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [31:0]               s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready
);

  //------------------------------------------------------------
  // declarations
  //------------------------------------------------------------
  afifo_pkg::afifo_pins_type pins_s1;
  afifo_pkg::afifo_pins_type pins_s2;
  afifo_pkg::afifo_word_type din_s1;
  afifo_pkg::afifo_word_type din_s2;
  logic                      ld_s3;
  logic                      ul_s3;
  logic                      ld_rise;
  logic                      ul_rise;
  logic                      ld_ok;
  logic                      ul_ok;
  logic                      clr;
  logic                      soft_clr_r;
  afifo_pkg::afifo_ptr_type  wr_ptr_r;
  afifo_pkg::afifo_ptr_type  rd_ptr_r;
  afifo_pkg::afifo_ptr_type  wr_ptr_nxt;
  afifo_pkg::afifo_ptr_type  rd_ptr_nxt;
  afifo_pkg::afifo_ptr_type  count_r;
  afifo_pkg::afifo_ptr_type  count_nxt;
  afifo_pkg::afifo_word_type mem_r [16];
  afifo_pkg::afifo_word_type q_r;
  afifo_pkg::afifo_word_type q_nxt;
  logic [31:0]               aw_addr_r;
  logic [31:0]               w_data_r;
  logic [3:0]                w_strb_r;
  logic                      wr_fire;

  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------
  function automatic afifo_pkg::afifo_flags_type flags_of(input afifo_pkg::afifo_ptr_type cnt);
    afifo_pkg::afifo_flags_type f;
    f.no_room_n  = (cnt != `AFIFO_DEPTH);
    f.one_slot_n = (cnt != `AFIFO_DEPTH_M1);
    f.no_words_n = (cnt != `AFIFO_ZERO);
    f.one_word_n = (cnt != `AFIFO_ONE);
    return f;
  endfunction

  function automatic logic addr_known(input logic [31:0] addr);
    logic k;
    k = 1'b0;
    if (addr == `AFIFO_CTRL_OFF) begin
      k = 1'b1;
    end else if (addr == `AFIFO_STATUS_OFF) begin
      k = 1'b1;
    end else if (addr == `AFIFO_DATA_OFF) begin
      k = 1'b1;
    end
    return k;
  endfunction

  //------------------------------------------------------------
  // pin synchronisers and edge detection
  //------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pins_s1 <= afifo_pkg::afifo_pins_type'(`AFIFO_PINS_RST);
      pins_s2 <= afifo_pkg::afifo_pins_type'(`AFIFO_PINS_RST);
      din_s1  <= 5'h00;
      din_s2  <= 5'h00;
      ld_s3   <= 1'b0;
      ul_s3   <= 1'b0;
    end else begin
      pins_s1 <= {load_strobe, unload_strobe, reset_n, drive_en};
      pins_s2 <= pins_s1;
      din_s1  <= data_in;
      din_s2  <= din_s1;
      ld_s3   <= pins_s2.load;
      ul_s3   <= pins_s2.unload;
    end
  end

  // each strobe has its own detector, no ordering between them
  assign ld_rise = pins_s2.load & ~ld_s3;
  assign ul_rise = pins_s2.unload & ~ul_s3;

  // pin reset is a level; soft clear is a one-cycle pulse
  assign clr = ~pins_s2.reset_n | soft_clr_r;

  //------------------------------------------------------------
  // pointers and occupancy
  //------------------------------------------------------------
  assign count_r = wr_ptr_r - rd_ptr_r;
  assign ld_ok   = ld_rise & (count_r != `AFIFO_DEPTH) & ~clr;
  assign ul_ok   = ul_rise & (count_r != `AFIFO_ZERO) & ~clr;

  always_comb begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    if (clr) begin
      wr_ptr_nxt = `AFIFO_ZERO;
      rd_ptr_nxt = `AFIFO_ZERO;
    end else begin
      if (ld_ok) begin
        wr_ptr_nxt = wr_ptr_r + `AFIFO_ONE;
      end
      if (ul_ok) begin
        rd_ptr_nxt = rd_ptr_r + `AFIFO_ONE;
      end
    end
  end

  assign count_nxt = wr_ptr_nxt - rd_ptr_nxt;

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= `AFIFO_ZERO;
      rd_ptr_r <= `AFIFO_ZERO;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
    end
  end

  //------------------------------------------------------------
  // storage, left without reset so stale words stay undefined
  //------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (ld_ok) begin
      mem_r[wr_ptr_r[3:0]] <= din_s2;
    end
  end

  //------------------------------------------------------------
  // head word, with fall-through when the load fills the head slot
  //------------------------------------------------------------
  always_comb begin
    q_nxt = q_r;
    if (count_nxt != `AFIFO_ZERO && !clr) begin
      if (ld_ok && wr_ptr_r[3:0] == rd_ptr_nxt[3:0]) begin
        q_nxt = din_s2;
      end else begin
        q_nxt = mem_r[rd_ptr_nxt[3:0]];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_r <= 5'h00;
    end else begin
      q_r <= q_nxt;
    end
  end

  //------------------------------------------------------------
  // pin outputs
  //------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      q_out     <= 5'h00;
      q_oe      <= 5'h00;
      flags_out <= afifo_pkg::afifo_flags_type'(`AFIFO_FLAGS_RST);
    end else begin
      q_out     <= q_nxt;
      q_oe      <= {5{pins_s2.drive_en}};
      flags_out <= flags_of(count_nxt);
    end
  end

  //------------------------------------------------------------
  // axi4-lite write channel
  //------------------------------------------------------------
  assign wr_fire = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AFIFO_RESP_OKAY;
      aw_addr_r     <= 32'h0000_0000;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr_r     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_known(aw_addr_r) ? `AFIFO_RESP_OKAY : `AFIFO_RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // writing one to the clear bit empties the fifo like the reset pin
  always_ff @(posedge clk) begin
    if (rst) begin
      soft_clr_r <= 1'b0;
    end else begin
      soft_clr_r <= wr_fire && (aw_addr_r == `AFIFO_CTRL_OFF) && w_strb_r[0]
                    && w_data_r[`AFIFO_CTRL_CLR_BIT];
    end
  end

  //------------------------------------------------------------
  // axi4-lite read channel
  //------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `AFIFO_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= addr_known(s_axi_araddr) ? `AFIFO_RESP_OKAY : `AFIFO_RESP_DECERR;
        s_axi_rdata   <= 32'h0000_0000;
        if (s_axi_araddr == `AFIFO_STATUS_OFF) begin
          s_axi_rdata[`AFIFO_STAT_CNT_LSB +: 5]  <= count_r;
          s_axi_rdata[`AFIFO_STAT_FLAG_LSB +: 4] <= flags_out;
          s_axi_rdata[`AFIFO_STAT_OE_BIT]        <= pins_s2.drive_en;
        end else if (s_axi_araddr == `AFIFO_DATA_OFF) begin
          s_axi_rdata[4:0] <= q_r;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  //------------------------------------------------------------
  // assertions
  //------------------------------------------------------------
  full_ignores_a: assert property (@(posedge clk) disable iff (rst)
    (count_r == `AFIFO_DEPTH) && ld_rise && !ul_rise && !clr |=>
      (wr_ptr_r == $past(wr_ptr_r)) && !flags_out.no_room_n)
    else $error("load taken while full");

  empty_ignores_a: assert property (@(posedge clk) disable iff (rst)
    (count_r == `AFIFO_ZERO) && ul_rise && !ld_rise && !clr |=>
      (rd_ptr_r == $past(rd_ptr_r)) && !flags_out.no_words_n)
    else $error("unload taken while empty");

  load_store_a: assert property (@(posedge clk) disable iff (rst)
    ld_ok |=> (mem_r[$past(wr_ptr_r[3:0])] == $past(din_s2)) &&
              (wr_ptr_r == $past(wr_ptr_r) + 5'h01))
    else $error("load word not stored");

  unload_step_a: assert property (@(posedge clk) disable iff (rst)
    ul_ok |=> rd_ptr_r == $past(rd_ptr_r) + 5'h01)
    else $error("unload did not advance");

  no_room_a: assert property (@(posedge clk) disable iff (rst)
    flags_out.no_room_n == (count_r != `AFIFO_DEPTH))
    else $error("no-room flag wrong");

  one_slot_a: assert property (@(posedge clk) disable iff (rst)
    flags_out.one_slot_n == (count_r != `AFIFO_DEPTH_M1))
    else $error("one-slot flag wrong");

  no_words_a: assert property (@(posedge clk) disable iff (rst)
    flags_out.no_words_n == (count_r != `AFIFO_ZERO))
    else $error("no-words flag wrong");

  one_word_a: assert property (@(posedge clk) disable iff (rst)
    flags_out.one_word_n == (count_r != `AFIFO_ONE))
    else $error("one-word flag wrong");

  pin_clear_a: assert property (@(posedge clk) disable iff (rst)
    clr |=> (wr_ptr_r == `AFIFO_ZERO) && (rd_ptr_r == `AFIFO_ZERO) &&
            !flags_out.no_words_n && flags_out.no_room_n && flags_out.one_word_n)
    else $error("clear did not empty fifo");

  first_word_a: assert property (@(posedge clk) disable iff (rst)
    ld_ok && (count_r == `AFIFO_ZERO) |=> (q_out == $past(din_s2)) && flags_out.no_words_n)
    else $error("first word not shown");

  head_word_a: assert property (@(posedge clk) disable iff (rst)
    (count_r != `AFIFO_ZERO) |-> (q_out == mem_r[rd_ptr_r[3:0]]) && (q_out == q_r))
    else $error("head word not shown");

  drive_follow_a: assert property (@(posedge clk) disable iff (rst)
    $rose(pins_s2.drive_en) |=> (q_oe == 5'h1f) [*2])
    else $error("drive enable not followed");

endmodule // afifo_top
